// ===== src/qgs_pkg.sv
// qgs_pkg: constants for the converter-unit global status register
// assumes: one 25 MHz clock, local register port from the host bridge
package qgs_pkg;
	// =====================================================================
	// register map
	localparam logic [9:0] STATUS_OFFSET = 10'h08C;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam int UNIT_COUNT = 8;
	localparam int NIBBLE = 4;
	// =====================================================================
	// bit positions inside each nibble
	localparam int BIT_BUSY = 0;
	localparam int BIT_SETTLE = 1;
	localparam int BIT_REQ = 2;
	localparam int BIT_UNDER = 3;
	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_TIME_NS = 10000;
	localparam int SETTLE_CYCLES = SETTLE_TIME_NS / CLK_PERIOD_NS;
	localparam int SETTLE_CNT_W = 9;
	// =====================================================================
	// unit control modes
	typedef enum logic [1:0] {
		MODE_IMMEDIATE,
		MODE_DEFERRED,
		MODE_TIMED,
		MODE_QUEUE
	} qgs_mode_type;
endpackage : qgs_pkg

// ===== src/qgs_status.sv
// qgs_status: global status register for eight converter units
// assumes: local register port of the bridge, same clock as unit control
//
// Overview of operation
// R1: four bits per unit, unit one lowest
// R2: timed fetch with pending request sets underflow
// R3: underflow never alters sequencer data path
// R4: timed-mode data request sets request flag
// R5: write one clears flag, zero keeps
// R6: flags meaningless and unset in queue mode
// R7: settle high ten microseconds after update
// R8: busy while converter transfer runs
// R9: data writes accepted during transfers
// R10: busy while deferred unit awaits load
// R11: busy while sequencer runs, clears at idle
// R12: software refills data then acknowledges request
// R13: flags never halt the sequencer
// R14: hardware set beats software clear
`timescale 1ns/10ps
module qgs_status #(
	parameter int UNITS = qgs_pkg::UNIT_COUNT,
	parameter int SETTLE_CYCLES = qgs_pkg::SETTLE_CYCLES
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic reset, // async reset, high
	input wire logic [9:0] regAddr, // local byte address
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	input wire logic [31:0] regWdata, // write data
	input wire logic [2*UNITS-1:0] unitMode, // mode per unit, two bits each
	input wire logic [UNITS-1:0] seqFetch, // sequencer fetch pulses
	input wire logic [UNITS-1:0] outputUpdate, // analog update pulses
	input wire logic [UNITS-1:0] xferActive, // converter transfer levels
	input wire logic [UNITS-1:0] loadWait, // load-wait levels
	input wire logic [UNITS-1:0] seqRunning, // sequencer run levels
	input wire logic [UNITS-1:0] ctrlIdle, // control idle levels
	output logic [31:0] regRdata, // read data
	output logic regAck, // access done
	output logic [UNITS-1:0] seqStall // always low, flags never stall
);
	logic [31:0] statusWord;
	logic [31:0] regRdata_r;
	logic regAck_r;
	// =====================================================================
	// decode
	wire hitStatus = (regAddr == qgs_pkg::STATUS_OFFSET);
	wire clrStrobe = regWrite && hitStatus; // R5
	wire [31:0] readMux = hitStatus ? statusWord : 32'h0000_0000;
	wire [31:0] clrMask = clrStrobe ? regWdata : 32'h0000_0000;

	// =====================================================================
	// per-unit status nibbles
	genvar u;
	generate
		for (u = 0; u < UNITS; u++) begin : gUnit
			qgs_unit #(
				.SETTLE_CYCLES(SETTLE_CYCLES)
			) uUnit (
				.ref_clk(ref_clk),
				.reset(reset),
				.mode(qgs_pkg::qgs_mode_type'(unitMode[2*u +: 2])),
				.seqFetch(seqFetch[u]),
				.outputUpdate(outputUpdate[u]),
				.xferActive(xferActive[u]),
				.loadWait(loadWait[u]),
				.seqRunning(seqRunning[u]),
				.ctrlIdle(ctrlIdle[u]),
				.clrUnder(clrMask[u*qgs_pkg::NIBBLE + qgs_pkg::BIT_UNDER]), // R5
				.clrReq(clrMask[u*qgs_pkg::NIBBLE + qgs_pkg::BIT_REQ]), // R5
				.nibble(statusWord[u*qgs_pkg::NIBBLE +: qgs_pkg::NIBBLE]) // R1
			);
		end
		if (UNITS * qgs_pkg::NIBBLE < 32) begin : gPad
			assign statusWord[31:UNITS*qgs_pkg::NIBBLE] = '0;
		end
	endgenerate

	// =====================================================================
	// register port: writes never blocked, one-cycle answer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			regRdata_r <= qgs_pkg::STATUS_RESET;
			regAck_r <= 1'b0;
		end else begin
			regRdata_r <= regRead ? readMux : regRdata_r;
			regAck_r <= regRead || regWrite; // R9
		end
	end
	assign regRdata = regRdata_r;
	assign regAck = regAck_r;

	// sequencer is never held by a flag; kept as a register for clean output
	logic [UNITS-1:0] seqStall_r;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			seqStall_r <= '0;
		end else begin
			seqStall_r <= '0; // R3 R13
		end
	end
	assign seqStall = seqStall_r;

	ack_one_a: assert property (@(posedge ref_clk) disable iff (reset) // R9
		(regWrite || regRead) |=> regAck)
		else $error("access not answered");
	read_data_a: assert property (@(posedge ref_clk) disable iff (reset) // R1
		(regRead && hitStatus) |=> (regRdata == $past(statusWord)))
		else $error("status read wrong");
	never_stall_a: assert property (@(posedge ref_clk) disable iff (reset) // R13
		(|statusWord) |-> (seqStall == '0))
		else $error("flag stalled sequencer");
endmodule : qgs_status

// ===== src/qgs_unit.sv
// qgs_unit: one converter unit's four status bits
// assumes: events come from same-clock control logic, clear from register write
`timescale 1ns/10ps
module qgs_unit #(
	parameter int SETTLE_CYCLES = qgs_pkg::SETTLE_CYCLES
) (
	input wire logic ref_clk, // clock
	input wire logic reset, // async reset, high
	input wire qgs_pkg::qgs_mode_type mode, // unit mode
	input wire logic seqFetch, // sequencer fetches data for next sequence
	input wire logic outputUpdate, // analog outputs updated
	input wire logic xferActive, // transfer to converter running
	input wire logic loadWait, // deferred unit waiting for load
	input wire logic seqRunning, // sequencer running
	input wire logic ctrlIdle, // control logic idle
	input wire logic clrUnder, // write-one clear of underflow
	input wire logic clrReq, // write-one clear of request
	output logic [3:0] nibble // status nibble
);
	logic underFlag_r;
	logic reqFlag_r;
	logic settle_r;
	logic busy_r;
	logic [qgs_pkg::SETTLE_CNT_W-1:0] settleCnt_r;
	// =====================================================================
	// event decode
	wire timedFetch = seqFetch && (mode == qgs_pkg::MODE_TIMED); // R6
	wire underSet = timedFetch && reqFlag_r; // R2
	wire busyCause = xferActive || loadWait || seqRunning; // R8 R10 R11
	wire settleLast = (settleCnt_r == qgs_pkg::SETTLE_CNT_W'(1));
	// =====================================================================
	// flags: set wins over clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			underFlag_r <= 1'b0;
			reqFlag_r <= 1'b0;
		end else begin
			underFlag_r <= underSet | (underFlag_r & ~clrUnder); // R2 R5 R14
			reqFlag_r <= timedFetch | (reqFlag_r & ~clrReq); // R4 R5 R14
		end
	end
	// =====================================================================
	// settle timer, restarted by each update
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			settleCnt_r <= '0;
			settle_r <= 1'b0;
		end else if (outputUpdate) begin
			settleCnt_r <= qgs_pkg::SETTLE_CNT_W'(SETTLE_CYCLES); // R7
			settle_r <= 1'b1;
		end else if (settle_r) begin
			settleCnt_r <= settleCnt_r - qgs_pkg::SETTLE_CNT_W'(1);
			settle_r <= !settleLast; // R7
		end
	end
	// =====================================================================
	// busy holds until control is back in idle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
		end else if (busyCause) begin
			busy_r <= 1'b1; // R8 R10 R11
		end else if (ctrlIdle) begin
			busy_r <= 1'b0; // R11
		end
	end
	assign nibble = {underFlag_r, reqFlag_r, settle_r, busy_r}; // R1

	under_set_a: assert property (@(posedge ref_clk) disable iff (reset) // R2
		underSet |=> underFlag_r)
		else $error("underflow flag not set");
	set_priority_a: assert property (@(posedge ref_clk) disable iff (reset) // R14
		(timedFetch && clrReq) |=> reqFlag_r)
		else $error("request set lost to clear");
	queue_quiet_a: assert property (@(posedge ref_clk) disable iff (reset) // R6
		(mode == qgs_pkg::MODE_QUEUE && !reqFlag_r) |=> !reqFlag_r)
		else $error("request flag set in queue mode");
	settle_time_a: assert property (@(posedge ref_clk) disable iff (reset) // R7
		(outputUpdate ##1 !outputUpdate [*8]) |-> settle_r)
		else $error("settle dropped early");
	busy_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // R11
		(busy_r && !ctrlIdle && !busyCause) |=> busy_r)
		else $error("busy cleared while not idle");
endmodule : qgs_unit

// ===== testbench/qgs_host.sv
// qgs_host: host side of the strobe/ack register port
// assumes: one access per call, bench checks the answers
`timescale 1ns/10ps
module qgs_host (
	input wire logic ref_clk, // clock
	output logic [9:0] regAddr, // address
	output logic regWrite, // write strobe
	output logic regRead, // read strobe
	output logic [31:0] regWdata // write data
);
	initial begin
		regAddr = 10'h000;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 32'h0000_0000;
	end
	// =====================================================
	// one strobe per access, released lines show inverse
	task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		#1;
		regAddr = a;
		regWdata = d;
		regWrite = wr;
		regRead = !wr;
		@(posedge ref_clk);
		#1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask : access
endmodule : qgs_host

// ===== testbench/qgs_status_tb_top.sv
// qgs_status_tb_top: self-checking bench for the status register
// assumes: settle count shortened to 10 cycles
`timescale 1ns/10ps
module qgs_status_tb_top;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [9:0] regAddr;
	logic regWrite, regRead, regAck;
	logic [31:0] regWdata, regRdata;
	logic [15:0] unitMode = {8{2'h2}};
	logic [7:0] seqFetch = 8'h00, outputUpdate = 8'h00, xferActive = 8'h00;
	logic [7:0] loadWait = 8'h00, seqRunning = 8'h00, ctrlIdle = 8'hFF, seqStall;
	logic [32:0] notes[$];
	logic [32:0] n;
	logic [31:0] rs = 32'd75448;
	int fail_count = 0, checks_done = 0, u, w;
	localparam logic [9:0] A = qgs_pkg::STATUS_OFFSET;
	always #20 ref_clk = ~ref_clk;
	qgs_host i_qgs_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata));
	qgs_status #(.UNITS(8), .SETTLE_CYCLES(10)) i_qgs_status (.ref_clk(ref_clk),
		.reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
		.regWdata(regWdata), .unitMode(unitMode), .seqFetch(seqFetch),
		.outputUpdate(outputUpdate), .xferActive(xferActive), .loadWait(loadWait),
		.seqRunning(seqRunning), .ctrlIdle(ctrlIdle), .regRdata(regRdata),
		.regAck(regAck), .seqStall(seqStall));
	function automatic logic [31:0] bt(int b);
		return 32'h0000_0001 << (4 * u + b);
	endfunction : bt
	function automatic logic [31:0] next_rand();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : next_rand
	task automatic check(string nm, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (e !== s) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic rd(logic [9:0] a, logic [31:0] e);
		notes.push_back({1'b1, e});
		i_qgs_host.access(1'b0, a, next_rand());
	endtask : rd
	task automatic wr(logic [31:0] d);
		notes.push_back(33'h0_0000_0000);
		i_qgs_host.access(1'b1, A, d);
	endtask : wr
	task automatic pulse(int k);
		@(posedge ref_clk);
		#1;
		if (k == 0) seqFetch[u] = 1'b1; else outputUpdate[u] = 1'b1;
		@(posedge ref_clk);
		#1;
		seqFetch = 8'h00;
		outputUpdate = 8'h00;
	endtask : pulse
	task automatic cause(int k, logic v);
		if (k == 0) xferActive[u] = v; else if (k == 1) loadWait[u] = v; else seqRunning[u] = v;
	endtask : cause
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	// =====================================================
	// monitor: oldest note against each answer
	// falling edge: ack and read data stand there, no race with the launch edge
	always @(negedge ref_clk) begin
		if (regAck === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			if (n[32]) check("regRdata", n[31:0], regRdata);
			check("seqStall", 32'h0, {24'h0, seqStall});
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		u = next_rand() % 8;
		rd(A, qgs_pkg::STATUS_RESET);
		pulse(0);
		rd(A, bt(2));
		pulse(0);
		rd(A, bt(2) | bt(3));
		wr(32'h0000_0000);
		rd(A, bt(2) | bt(3));
		wr(bt(2));
		rd(A, bt(3));
		wr(bt(3));
		fork
			wr(bt(2));
			pulse(0);
		join
		rd(A, bt(2));
		// write elsewhere with the request bit set: must not clear anything
		notes.push_back(33'h0_0000_0000);
		i_qgs_host.access(1'b1, 10'h090, next_rand() | bt(2));
		rd(A, bt(2));
		wr(32'hCCCC_CCCC);
		for (int m = 0; m < 4; m++) begin
			if (m != 2) begin
				unitMode[2*u+:2] = m[1:0];
				pulse(0);
				rd(A, 32'h0);
			end
		end
		unitMode[2*u+:2] = 2'h2;
		pulse(1);
		rd(A, bt(1));
		// last read inside the ten-cycle window, then the first one after it
		repeat (5) @(posedge ref_clk);
		rd(A, bt(1));
		rd(A, 32'h0);
		for (int k = 0; k < 3; k++) begin
			cause(k, 1'b1);
			rd(A, bt(0));
			ctrlIdle[u] = 1'b0;
			cause(k, 1'b0);
			rd(A, bt(0));
			ctrlIdle[u] = 1'b1;
			rd(A, 32'h0);
		end
		rd(10'h090, 32'h0);
		for (w = 0; w < 20 && notes.size() > 0; w++) @(posedge ref_clk);
		if (notes.size() > 0) fail_count++;
		report_and_stop();
	end
endmodule : qgs_status_tb_top
